// [design/srs_sequencer.sv]
// Fundamental reset and initialization sequencer for a multi-port switch.
// Assumes pins synchronous to clock and a plain one-cycle register port.
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_sequencer import srs_pkg::*; #(
	parameter int TRAIN_CYC = `SRS_TRAIN_CYC,
	parameter int RETRY_CYC = `SRS_RETRY_CYC,
	parameter int EE_CYC = `SRS_EE_CYC,
	parameter int NORMAL_CYC = `SRS_NORMAL_CYC,
	parameter int GPIO_W = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Boot pins
	input wire logic fundamental_reset_n,
	input wire logic common_clock_downstream,
	input wire logic common_clock_upstream,
	input wire logic master_smbus_slow_select,
	input wire logic reset_halt_hold,
	input wire logic [3:0] switch_operating_select,
	input wire logic [3:0] slave_smbus_addr_pins,
	// Bring-up handshakes from the analog and stack side
	input wire logic pll_locked,
	input wire logic ee_done,
	input wire logic ee_error,
	input wire logic [7:0] ee_code,
	input wire logic hot_reset_req,
	input wire logic up_sbr_req,
	input wire logic [2:0] down_sbr_req,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Bring-up controls
	output logic pll_init,
	output logic link_train,
	output logic stack_reset,
	output logic stack_quasi,
	output logic core_reset,
	output logic sticky_reset,
	output logic [2:0] down_port_reset,
	output logic down_link_hot,
	output logic slave_smb_en,
	output logic [3:0] slave_smb_addr,
	output logic master_smb_en,
	output logic master_smb_tick,
	output logic ee_start,
	output logic [GPIO_W-1:0] gpio_oe,
	output logic normal_op,
	output logic deadline_miss
);
	initial begin
		if (TRAIN_CYC < 1 || RETRY_CYC < TRAIN_CYC || GPIO_W < 1) $error("bad sequencer parameters");
	end
	srs_phase_e phase_reg; // Current phase
	srs_boot_s boot_reg; // Boot vector in use
	srs_boot_s cold_reg; // Boot vector of last cold reset
	srs_load_s load_reg; // EEPROM loader result
	logic seen_cold_reg; // A cold capture exists
	logic pin_seen_reg; // Pin was asserted this reset
	logic halt_ctl_reg; // Control halt bit
	logic warm_pend_reg; // Warm request waiting on completion
	logic [31:0] since_reg; // Cycles since reset clear
	logic tick_wire; // Divider tick
	logic wr_ctl; // Write to control register
	logic in_fund; // Fundamental reset active
	assign wr_ctl = reg_write && reg_addr == `SRS_OFS_CONTROL;
	// Warm request is raised one cycle after its write so the write completes first
	assign in_fund = !fundamental_reset_n || warm_pend_reg;

	// Divider for master SMBus clock
	srs_divider #(.DIV_W(12)) u_div (
		.clock(clock),
		.reset(reset),
		.enable(master_smb_en),
		.slow(boot_reg.slow),
		.tick(tick_wire)
	);

	// Warm request latch
	always_ff @(posedge clock) begin
		if (reset) begin
			warm_pend_reg <= 1'b0;
		end else begin
			warm_pend_reg <= wr_ctl && reg_wdata[`SRS_CTL_WARM_BIT];
		end
	end

	// Main phase machine
	always_ff @(posedge clock) begin
		if (reset || in_fund) begin
			phase_reg <= SRS_IN_RESET;
		end else begin
			case (phase_reg)
				SRS_IN_RESET: phase_reg <= SRS_SAMPLE;
				SRS_SAMPLE: phase_reg <= SRS_PLL_INIT;
				SRS_PLL_INIT: begin
					if (pll_locked) phase_reg <= SRS_TRAIN_START;
				end
				SRS_TRAIN_START: phase_reg <= SRS_SMB_FREQ;
				SRS_SMB_FREQ: phase_reg <= SRS_SLAVE_INIT;
				SRS_SLAVE_INIT: phase_reg <= SRS_MASTER_INIT;
				SRS_MASTER_INIT: begin
					if (boot_reg.mode == `SRS_MODE_EEPROM) phase_reg <= SRS_EE_LOAD;
					else phase_reg <= SRS_HALTED;
				end
				SRS_EE_LOAD: begin
					if (ee_done || ee_error) phase_reg <= SRS_HALTED;
				end
				SRS_HALTED: begin
					if (!halt_ctl_reg) phase_reg <= SRS_RUNNING;
				end
				SRS_RUNNING: phase_reg <= SRS_RUNNING;
				default: phase_reg <= SRS_IN_RESET;
			endcase
		end
	end

	// Track whether the pin itself caused this reset
	always_ff @(posedge clock) begin
		if (reset) begin
			pin_seen_reg <= 1'b0;
		end else if (!fundamental_reset_n) begin
			pin_seen_reg <= 1'b1;
		end else if (phase_reg == SRS_SAMPLE) begin
			pin_seen_reg <= 1'b0;
		end
	end

	// Boot vector capture, only on pin release; software reset reuses old values
	always_ff @(posedge clock) begin
		if (reset) begin
			boot_reg <= '0;
			cold_reg <= '0;
			seen_cold_reg <= 1'b0;
		end else if (phase_reg == SRS_SAMPLE && pin_seen_reg) begin
			boot_reg <= '{common_clock_downstream, common_clock_upstream,
				master_smbus_slow_select, reset_halt_hold, switch_operating_select};
			// First capture after power-up is the cold one
			if (!seen_cold_reg) begin
				cold_reg <= '{common_clock_downstream, common_clock_upstream,
					master_smbus_slow_select, reset_halt_hold, switch_operating_select};
				seen_cold_reg <= 1'b1;
			end
		end
	end

	// Control halt bit: set by halt pin or EEPROM error, cleared by SMBus master
	always_ff @(posedge clock) begin
		// A fundamental reset reinitializes the halt bit as well, so no stale halt survives it
		if (reset || in_fund) begin
			halt_ctl_reg <= 1'b0;
		end else if (phase_reg == SRS_TRAIN_START && boot_reg.halt) begin
			halt_ctl_reg <= 1'b1;
		end else if (phase_reg == SRS_EE_LOAD && ee_error) begin
			halt_ctl_reg <= 1'b1;
		end else if (wr_ctl) begin
			halt_ctl_reg <= reg_wdata[`SRS_CTL_HALT_BIT];
		end
	end

	// Loader status: done on finish or abort, error details recorded
	always_ff @(posedge clock) begin
		if (reset || phase_reg == SRS_SAMPLE) begin
			load_reg <= '0;
		end else if (phase_reg == SRS_EE_LOAD && (ee_done || ee_error)) begin
			load_reg.done <= 1'b1;
			load_reg.error <= ee_error;
			load_reg.code <= ee_error ? ee_code : 8'h00;
		end
	end

	// Time since reset clear, saturating
	always_ff @(posedge clock) begin
		if (reset || in_fund) begin
			since_reg <= '0;
		end else if (since_reg != 32'hFFFF_FFFF) begin
			since_reg <= since_reg + 32'h0000_0001;
		end
	end

	// Bring-up outputs, all registered
	always_ff @(posedge clock) begin
		if (reset || in_fund) begin
			pll_init <= 1'b0;
			link_train <= 1'b0;
			stack_reset <= 1'b1;
			stack_quasi <= 1'b0;
			core_reset <= 1'b1;
			sticky_reset <= 1'b1;
			slave_smb_en <= 1'b0;
			slave_smb_addr <= 4'h0;
			master_smb_en <= 1'b0;
			ee_start <= 1'b0;
			normal_op <= 1'b0;
			gpio_oe <= '0;
		end else begin
			sticky_reset <= 1'b0;
			pll_init <= phase_reg == SRS_PLL_INIT;
			if (phase_reg == SRS_TRAIN_START) link_train <= 1'b1;
			if (phase_reg == SRS_TRAIN_START) begin
				// Stacks leave reset into retry-only quasi-reset
				stack_reset <= 1'b0;
				stack_quasi <= 1'b1;
			end
			if (phase_reg == SRS_SLAVE_INIT) begin
				slave_smb_en <= 1'b1;
				slave_smb_addr <= slave_smbus_addr_pins;
			end
			if (phase_reg == SRS_MASTER_INIT) master_smb_en <= 1'b1;
			ee_start <= phase_reg == SRS_MASTER_INIT && boot_reg.mode == `SRS_MODE_EEPROM;
			if (phase_reg == SRS_RUNNING) begin
				stack_quasi <= 1'b0;
				core_reset <= 1'b0;
				normal_op <= 1'b1;
			end
			// Hot reset reruns core logic but leaves sticky state alone
			if (hot_reset_req && phase_reg == SRS_RUNNING) core_reset <= 1'b1;
		end
	end

	// Secondary bus resets
	always_ff @(posedge clock) begin
		if (reset) begin
			down_port_reset <= '0;
			down_link_hot <= 1'b0;
		end else begin
			// Upstream bus reset covers all downstream ports, not the upstream bridge
			// A downstream bus reset hot resets only the port that asked for it
			down_port_reset <= up_sbr_req ? 3'b111 : down_sbr_req;
			// Any downstream bus reset raises the single shared down_link_hot, whichever port asked for it
			down_link_hot <= |down_sbr_req;
		end
	end

	// Deadline monitor and SMBus tick
	always_ff @(posedge clock) begin
		if (reset || in_fund) begin
			deadline_miss <= 1'b0;
			master_smb_tick <= 1'b0;
		end else begin
			master_smb_tick <= tick_wire;
			if (since_reg >= 32'(NORMAL_CYC) && !normal_op && !halt_ctl_reg) deadline_miss <= 1'b1;
		end
	end

	// Register read port, data in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (reset) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			case (reg_addr)
				`SRS_OFS_CONTROL: reg_rdata <= {31'h0, halt_ctl_reg};
				`SRS_OFS_STATUS: reg_rdata <= {20'h0_0000, 4'(phase_reg), cold_reg.mode,
					halt_ctl_reg, cold_reg.slow, cold_reg.cclk_us, cold_reg.cclk_ds};
				`SRS_OFS_SMBUS: reg_rdata <= {16'h0000, load_reg.code, 6'h00, load_reg.error, load_reg.done};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Checks
	AST_TRAIN_BY_LIMIT: assert property (@(posedge clock) disable iff (reset || in_fund)
		since_reg == 32'(TRAIN_CYC) |-> link_train) else $error("training not started in time");
	AST_RETRY_BY_LIMIT: assert property (@(posedge clock) disable iff (reset || in_fund)
		since_reg == 32'(RETRY_CYC) |-> !stack_reset) else $error("stacks not answering in time");
	AST_HALT_HOLDS: assert property (@(posedge clock) disable iff (reset)
		phase_reg == SRS_HALTED && halt_ctl_reg |=> core_reset) else $error("core left reset while halted");
	AST_EE_ERR_HALT: assert property (@(posedge clock) disable iff (reset || in_fund)
		phase_reg == SRS_EE_LOAD && ee_error |=> halt_ctl_reg && load_reg.error) else $error("error not halting");
	AST_DONE_FLAG: assert property (@(posedge clock) disable iff (reset || in_fund)
		phase_reg == SRS_EE_LOAD && (ee_done || ee_error) |=> load_reg.done) else $error("done not set");
	AST_WARM_AFTER_WRITE: assert property (@(posedge clock) disable iff (reset)
		wr_ctl && reg_wdata[`SRS_CTL_WARM_BIT] |-> phase_reg != SRS_IN_RESET || !fundamental_reset_n
		##1 phase_reg != SRS_IN_RESET || !fundamental_reset_n ##1 phase_reg == SRS_IN_RESET)
		else $error("warm reset not one cycle after write");
	AST_SMB_ORDER: assert property (@(posedge clock) disable iff (reset)
		$rose(master_smb_en) |-> slave_smb_en) else $error("master SMBus before slave");
	AST_GPIO_INPUT: assert property (@(posedge clock) disable iff (reset)
		$past(in_fund) |-> gpio_oe == '0) else $error("general pins driven after reset");
endmodule // srs_sequencer

// [design/srs_defs.svh]
// Constants for the switch reset and initialization sequencer.
// Assumes inclusion by bare name from both design modules.
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH
// Register offsets on the plain register port
`define SRS_OFS_CONTROL 8'h00
`define SRS_OFS_STATUS 8'h04
`define SRS_OFS_SMBUS 8'h08
`define SRS_OFS_EEPROM 8'h0C
// Control register fields
`define SRS_CTL_HALT_BIT 0
`define SRS_CTL_WARM_BIT 1
`define SRS_CTL_HOT_BIT 2
// Status register fields
`define SRS_STS_COMMON_CLOCK_DOWNSTREAM_BIT 0
`define SRS_STS_COMMON_CLOCK_UPSTREAM_BIT 1
`define SRS_STS_SLOW_BIT 2
`define SRS_STS_HALT_BIT 3
`define SRS_STS_MODE_LSB 4
`define SRS_STS_PHASE_LSB 8
// SMBus status register fields
`define SRS_SMB_DONE_BIT 0
`define SRS_SMB_ERR_BIT 1
`define SRS_SMB_CODE_LSB 8
// Mode codes
`define SRS_MODE_NORMAL 4'h0
`define SRS_MODE_EEPROM 4'h1
// Times and derived cycle counts at 200 MHz
`define SRS_CLK_MHZ 200
`define SRS_TRAIN_MS 20
`define SRS_RETRY_MS 100
`define SRS_EE_MS 200
`define SRS_NORMAL_MS 1000
`define SRS_TRAIN_CYC (`SRS_TRAIN_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_RETRY_CYC (`SRS_RETRY_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_EE_CYC (`SRS_EE_MS * 1000 * `SRS_CLK_MHZ)
`define SRS_NORMAL_CYC (`SRS_NORMAL_MS * 1000 * `SRS_CLK_MHZ)
// Master SMBus rates
`define SRS_SMB_SLOW_KHZ 100
`define SRS_SMB_FAST_KHZ 400
`define SRS_SMB_SLOW_DIV (`SRS_CLK_MHZ * 1000 / `SRS_SMB_SLOW_KHZ)
`define SRS_SMB_FAST_DIV (`SRS_CLK_MHZ * 1000 / `SRS_SMB_FAST_KHZ)
`endif

// [design/srs_pkg.sv]
// Types shared by the reset sequencer modules.
// Assumes srs_defs.svh is on the include path.
package srs_pkg;
	// Sequencer phases
	typedef enum logic [3:0] {
		SRS_IN_RESET,
		SRS_SAMPLE,
		SRS_PLL_INIT,
		SRS_TRAIN_START,
		SRS_SMB_FREQ,
		SRS_SLAVE_INIT,
		SRS_MASTER_INIT,
		SRS_EE_LOAD,
		SRS_HALTED,
		SRS_RUNNING
	} srs_phase_e;
	// Captured boot vector
	typedef struct packed {
		logic cclk_ds;
		logic cclk_us;
		logic slow;
		logic halt;
		logic [3:0] mode;
	} srs_boot_s;
	// Loader answer
	typedef struct packed {
		logic done;
		logic error;
		logic [7:0] code;
	} srs_load_s;
endpackage

// [design/srs_divider.sv]
// Master SMBus bit-rate tick generator.
// Assumes the rate select is stable while enabled.
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_divider import srs_pkg::*; #(
	parameter int DIV_W = 12
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Control
	input wire logic enable,
	input wire logic slow,
	// Tick out
	output logic tick
);
	initial begin
		if (DIV_W < 11) $error("divider width too small");
	end
	logic [DIV_W-1:0] count_reg;
	logic [DIV_W-1:0] limit;
	// Rate is fixed by the select pin alone
	assign limit = slow ? DIV_W'(`SRS_SMB_SLOW_DIV - 1) : DIV_W'(`SRS_SMB_FAST_DIV - 1);
	// Free-running divider while enabled
	always_ff @(posedge clock) begin
		if (reset || !enable) begin
			count_reg <= '0;
			tick <= 1'b0;
		end else if (count_reg >= limit) begin
			count_reg <= '0;
			tick <= 1'b1;
		end else begin
			count_reg <= count_reg + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // srs_divider

// [sim/srs_partner.sv]
// Far-side model: analog PLL lock answer and serial EEPROM loader.
// Assumes ee_start is a one-cycle pulse and pll_init a level.
`timescale 1ns/1ps
module srs_partner #(
	parameter int LOCK_CYC = 8,
	parameter int LOAD_CYC = 40
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// From the sequencer
	input wire logic pll_init,
	input wire logic ee_start,
	// Bench knob: answer the load with an error
	input wire logic fail_load,
	// Answers
	output logic pll_locked,
	output logic ee_done,
	output logic ee_error,
	output logic [7:0] ee_code
);
	int lock_cnt; // Cycles spent waiting for lock
	int load_cnt; // Remaining load cycles, 0 when idle
	logic pll_init_q; // Edge finder, so a new request relocks
	// Lock comes some cycles after the request and holds only while pll_init stays high
	always_ff @(posedge clock) begin
		pll_init_q <= pll_init;
		if (reset || (pll_init && !pll_init_q)) begin
			lock_cnt <= 0;
		end else if (pll_init && lock_cnt < LOCK_CYC) begin
			lock_cnt <= lock_cnt + 1;
		end
	end
	assign pll_locked = pll_init && (lock_cnt >= LOCK_CYC);
	// Image sized to load well inside the deadline, and it holds no trigger writes
	// ahead of the configuration that they depend on
	always_ff @(posedge clock) begin
		ee_done <= 1'b0;
		ee_error <= 1'b0;
		if (reset) begin
			load_cnt <= 0;
			ee_code <= 8'h00;
		end else if (ee_start) begin
			load_cnt <= LOAD_CYC;
		end else if (load_cnt == 1) begin
			load_cnt <= 0;
			ee_done <= !fail_load;
			ee_error <= fail_load;
			ee_code <= fail_load ? 8'h5A : 8'h00;
		end else if (load_cnt > 1) begin
			load_cnt <= load_cnt - 1;
			ee_code <= ~ee_code; // Code has no meaning outside the error pulse
		end
	end
endmodule // srs_partner

// [sim/switch_reset_init_sequencer_tb_top.sv]
// Self-checking bench for the reset and initialization sequencer.
// Assumes the design package and srs_partner are compiled first.
`timescale 1ns/1ps
module switch_reset_init_sequencer_tb_top import srs_pkg::*; ;
	logic clock = 0, reset = 1, fundamental_reset_n = 0, cc_ds = 0, cc_us = 0, slow = 0, halt = 0;
	logic [3:0] mode = 4'h0, saddr = 4'hA;
	logic pll_locked, ee_done, ee_error, fail_load = 0, hot_reset_req = 0, up_sbr_req = 0;
	logic [7:0] ee_code, reg_addr = 8'h00;
	logic [2:0] down_sbr_req = 3'h0, down_port_reset;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd_val;
	logic reg_write = 0, reg_read = 0, pll_init, link_train, stack_reset, stack_quasi, core_reset, sticky_reset;
	logic down_link_hot, slave_smb_en, master_smb_en, master_smb_tick, ee_start, normal_op, deadline_miss;
	logic [3:0] slave_smb_addr;
	logic [7:0] gpio_oe;
	int num_errors = 0, check_count = 0;
	// Five ns period
	always #2.5 clock = ~clock;
	// Short counts keep the run small
	srs_sequencer #(.TRAIN_CYC(100), .RETRY_CYC(200), .EE_CYC(400), .NORMAL_CYC(1000)) dut_u (.clock(clock),
		.reset(reset), .fundamental_reset_n(fundamental_reset_n), .common_clock_downstream(cc_ds),
		.common_clock_upstream(cc_us), .master_smbus_slow_select(slow), .reset_halt_hold(halt),
		.switch_operating_select(mode), .slave_smbus_addr_pins(saddr), .pll_locked(pll_locked), .ee_done(ee_done),
		.ee_error(ee_error), .ee_code(ee_code), .hot_reset_req(hot_reset_req), .up_sbr_req(up_sbr_req),
		.down_sbr_req(down_sbr_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .pll_init(pll_init), .link_train(link_train),
		.stack_reset(stack_reset), .stack_quasi(stack_quasi), .core_reset(core_reset), .sticky_reset(sticky_reset),
		.down_port_reset(down_port_reset), .down_link_hot(down_link_hot), .slave_smb_en(slave_smb_en),
		.slave_smb_addr(slave_smb_addr), .master_smb_en(master_smb_en), .master_smb_tick(master_smb_tick),
		.ee_start(ee_start), .gpio_oe(gpio_oe), .normal_op(normal_op), .deadline_miss(deadline_miss));
	// Far side
	srs_partner part_u (.clock(clock), .reset(reset), .pll_init(pll_init), .ee_start(ee_start),
		.fail_load(fail_load), .pll_locked(pll_locked), .ee_done(ee_done), .ee_error(ee_error), .ee_code(ee_code));
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	// One-cycle read, data taken in the following cycle only
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	// Wait for normal operation under a bound
	task automatic wait_run();
		for (int i = 0; i < 1500 && normal_op !== 1'b1; i++) @(posedge clock);
		chk(normal_op, 1, "normal operation not reached");
	endtask
	// Measure the master SMBus tick period
	task automatic tick_gap(input int exp);
		int n;
		for (n = 0; n < 3000 && master_smb_tick !== 1'b1; n++) @(posedge clock);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (master_smb_tick !== 1'b1 && n < 3000);
		chk(n, exp, "tick period");
	endtask
	// Pin-driven fundamental reset with a given boot vector
	task automatic pin_boot(input logic [3:0] m, input logic s, input logic h);
		int n;
		@(posedge clock);
		fundamental_reset_n <= 1'b0;
		repeat (20) @(posedge clock);
		chk(sticky_reset, 1, "sticky not reset");
		chk(normal_op, 0, "running in reset");
		mode <= m;
		slow <= s;
		halt <= h;
		@(posedge clock);
		fundamental_reset_n <= 1'b1;
		for (n = 0; n < 1000 && link_train !== 1'b1; n++) @(posedge clock);
		chk(n <= 100, 1, "training late");
		for (n = 0; n < 1000 && stack_quasi !== 1'b1; n++) @(posedge clock);
		chk(n <= 200, 1, "retry stacks late");
	endtask
	// Cold boot in EEPROM mode, then pin changes that must not matter
	task automatic t_cold();
		pin_boot(4'h1, 1'b1, 1'b0);
		wait_run();
		rd(8'h04);
		chk(rd_val, {20'h0_0000, SRS_RUNNING, 4'h1, 4'h5}, "status");
		rd(8'h08);
		chk(rd_val & 32'h0000_0003, 32'h0000_0001, "load done");
		chk(slave_smb_addr, 4'hA, "slave address");
		chk(master_smb_en & slave_smb_en, 1, "smbus enables");
		chk(gpio_oe, 8'h00, "gpio driven");
		tick_gap(2000);
		cc_ds <= 1'b0;
		mode <= 4'h0;
		slow <= 1'b0;
		halt <= 1'b1;
		repeat (10) @(posedge clock);
		rd(8'h04);
		chk(rd_val, {20'h0_0000, SRS_RUNNING, 4'h1, 4'h5}, "pins outside reset");
	endtask
	// Software warm reset reuses the captured vector
	task automatic t_warm();
		wr(8'h00, 32'h0000_0002);
		chk(normal_op, 1, "reset before write done");
		repeat (2) @(posedge clock);
		chk(core_reset, 1, "warm request ignored");
		wait_run();
		tick_gap(2000);
		rd(8'h0C);
		chk(rd_val, 0, "unmapped read");
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10);
		chk(rd_val, 0, "unmapped read");
	endtask
	// Halt pin holds the device until software clears it
	task automatic t_halt();
		cc_ds <= 1'b1;
		pin_boot(4'h0, 1'b0, 1'b1);
		repeat (300) @(posedge clock);
		chk(normal_op, 0, "halt ignored");
		chk(core_reset, 1, "core out of reset");
		rd(8'h04);
		chk(rd_val & 32'h0000_00F8, 32'h0000_0018, "halt status");
		tick_gap(500);
		wr(8'h00, 32'h0000_0000);
		wait_run();
	endtask
	// EEPROM error aborts the load and halts
	task automatic t_load_err();
		fail_load <= 1'b1;
		halt <= 1'b0;
		pin_boot(4'h1, 1'b1, 1'b0);
		repeat (300) @(posedge clock);
		rd(8'h08);
		chk(rd_val & 32'h0000_FF03, 32'h0000_5A03, "error record");
		rd(8'h00);
		chk(rd_val & 32'h0000_0001, 1, "halt not set");
		chk(normal_op, 0, "ran after error");
		fail_load <= 1'b0;
		wr(8'h00, 32'h0000_0000);
		wait_run();
	endtask
	// Hot and bus resets while running
	task automatic t_hot();
		down_sbr_req <= 3'b010;
		repeat (4) @(posedge clock);
		chk(down_port_reset, 3'b010, "own port only");
		chk(down_link_hot, 1, "own link hot reset");
		down_sbr_req <= 3'b000;
		up_sbr_req <= 1'b1;
		repeat (4) @(posedge clock);
		chk(down_port_reset, 3'b111, "all downstream");
		up_sbr_req <= 1'b0;
		hot_reset_req <= 1'b1;
		repeat (4) @(posedge clock);
		chk(core_reset, 1, "hot reset core");
		chk(sticky_reset, 0, "hot reset sticky");
		hot_reset_req <= 1'b0;
		chk(deadline_miss, 0, "deadline flagged");
	endtask
	// Verdict and end of run
	task automatic finish_test();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		cc_ds = 1'b1;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		t_cold();
		t_warm();
		t_halt();
		t_load_err();
		t_hot();
		finish_test();
	end
	// Hang guard, well above the expected length
	initial begin
		#(60000 * 5);
		num_errors++;
		$display("Error at %0t: timeout", $time);
		finish_test();
	end
endmodule // switch_reset_init_sequencer_tb_top
